// >>> mode_sel_pkg.sv
// Purpose: Shared constants and types for the operation mode selector.
// Assumes: One 40 MHz control clock, asynchronous active-low reset.
// Notes:   Function codes are per-terminal, eight bits each.
package mode_sel_pkg;

  localparam logic [2:0] SEL_EXT_PU      = 3'h0;
  localparam logic [2:0] SEL_PU_FIXED    = 3'h1;
  localparam logic [2:0] SEL_EXT_FIXED   = 3'h2;
  localparam logic [2:0] SEL_COMB_1      = 3'h3;
  localparam logic [2:0] SEL_COMB_2      = 3'h4;
  localparam logic [2:0] SEL_SWITCHOVER  = 3'h6;
  localparam logic [2:0] SEL_INTERLOCK   = 3'h7;
  localparam logic [2:0] SEL_RESET       = SEL_EXT_PU;

  localparam int SPEED_W = 16;
  localparam int TERM_N  = 5;
  localparam int FUNC_W  = 8;

  localparam logic [FUNC_W-1:0] FUNC_INTERLOCK   = 8'h0c;
  localparam logic [FUNC_W-1:0] FUNC_OUTPUT_STOP = 8'h18;

  // Synchronised pin vector layout
  localparam int PIN_FWD      = 0;
  localparam int PIN_REV      = 1;
  localparam int PIN_CUR_SEL  = 2;
  localparam int PIN_INCHING  = 3;
  localparam int PIN_PRESET   = 4;
  localparam int KEY_FWD      = 5;
  localparam int KEY_REV      = 6;
  localparam int KEY_STOP     = 7;
  localparam int KEY_PU       = 8;
  localparam int KEY_EXT      = 9;
  localparam int PIN_TERM0    = 10;
  localparam int SYNC_W       = PIN_TERM0 + TERM_N;
  localparam int KEY_N        = 5;

  typedef enum logic [3:0] {
    MODE_EXT  = 4'h1,
    MODE_PU   = 4'h2,
    MODE_NET  = 4'h4,
    MODE_COMB = 4'h8
  } op_mode_t;

endpackage

// >>> pin_sync.sv
// Purpose: Two-stage synchroniser for all asynchronous pin inputs.
// Assumes: Pins are slow levels; no pulse shorter than two clocks.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module pin_sync (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic [mode_sel_pkg::SYNC_W-1:0] pins_async,
  output logic      [mode_sel_pkg::SYNC_W-1:0] pins_sync
);

  typedef struct packed {
    logic [mode_sel_pkg::SYNC_W-1:0] meta;
    logic [mode_sel_pkg::SYNC_W-1:0] stable;
  } sync_t;

  sync_t s_reg;
  sync_t s_next;

  always_comb begin
    s_next.meta   = pins_async;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins_sync = s_reg.stable;

endmodule

// >>> op_mode_selector.sv
// Purpose: Picks start and speed command sources from the mode setting.
// Assumes: Panel keys and terminals are raw pins; link strobes are
//          one-cycle pulses on clk; motor_running comes from clk logic.
// Notes:   Output-stop function code is a local choice.
//
// Overview of operation
// RQ1 - Settings 0 and 2 come up in external-terminal mode after reset.
// RQ2 - Setting 2 stays external; switching to panel mode is refused.
// RQ3 - Setting 0 lets a panel key move from external to panel mode.
// RQ4 - External mode: start from start pins, speed from terminals 2/4, presets, inching.
// RQ5 - External mode refuses panel parameter writes except designated ones; in setting 7 the code accepts them while the interlock is on.
// RQ6 - Setting 1 starts in panel mode and never changes mode.
// RQ7 - Setting 3: panel speed, external start switch, no mode changes.
// RQ8 - Setting 3: preset speed beats panel; current select picks terminal 4.
// RQ9 - Setting 4: external speed, panel start keys, no mode changes.
// RQ10 - Setting 6 allows panel, external, network switching while running.
// RQ11 - Running switch from external keeps direction and speed until a new panel or link command.
// RQ12 - Panel external key returns to external; external pins then rule.
// RQ13 - Panel to network by link command keeps panel direction and speed.
// RQ14 - Network master sends a command to return to external mode.
// RQ15 - Network to panel by panel key keeps network direction and speed.
// RQ16 - Setting 7 forces external mode while the interlock input is off.
// RQ17 - Interlock binds to any terminal whose function code equals 12.
// RQ18 - Without interlock terminal, an output-stop terminal acts as interlock.
// RQ19 - Interlock on: all switching allowed, output stopped in external mode.
// RQ20 - Interlock off: only mode-select writes accepted.
// RQ21 - Panel stop key works in every mode in the initial configuration.
// RQ22 - Mode select takes 0-4, 6, 7, reset 0, written only when stopped.
// RQ23 - Mode held in one-hot state; illegal select writes leave value intact.
`timescale 1ns/1ps
module op_mode_selector (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        forward_start_input,
  input  wire logic                        reverse_start_input,
  input  wire logic                        current_input_select,
  input  wire logic                        inching_speed_input,
  input  wire logic                        preset_speed_input,
  input  wire logic [mode_sel_pkg::TERM_N-1:0] term_pins,
  input  wire logic [mode_sel_pkg::TERM_N*mode_sel_pkg::FUNC_W-1:0]
                                           input_function_codes,
  input  wire logic [mode_sel_pkg::SPEED_W-1:0] terminal_2_speed,
  input  wire logic [mode_sel_pkg::SPEED_W-1:0] terminal_4_speed,
  input  wire logic [mode_sel_pkg::SPEED_W-1:0] preset_speed,
  input  wire logic [mode_sel_pkg::SPEED_W-1:0] inching_speed,
  input  wire logic                        panel_fwd_key,
  input  wire logic                        panel_rev_key,
  input  wire logic                        panel_stop_key,
  input  wire logic                        panel_mode_key,
  input  wire logic                        panel_ext_key,
  input  wire logic [mode_sel_pkg::SPEED_W-1:0] panel_speed,
  input  wire logic                        panel_speed_set,
  input  wire logic                        net_fwd,
  input  wire logic                        net_rev,
  input  wire logic [mode_sel_pkg::SPEED_W-1:0] net_speed,
  input  wire logic                        net_cmd_valid,
  input  wire logic                        net_to_ext_cmd,
  input  wire logic                        net_to_net_cmd,
  input  wire logic                        motor_running,
  input  wire logic                        stop_key_select,
  input  wire logic                        write_protect_select,
  input  wire logic                        wr_req,
  input  wire logic                        wr_is_mode_select,
  input  wire logic                        wr_ext_writable,
  input  wire logic [2:0]                  wr_mode_value,
  output logic                             wr_ack,
  output logic                             wr_nak,
  output logic [2:0]                       operation_mode_select,
  output logic [3:0]                       op_mode,
  output logic                             run_forward,
  output logic                             run_reverse,
  output logic [mode_sel_pkg::SPEED_W-1:0] speed_cmd,
  output logic                             output_stop,
  output logic                             interlock_active
);

  localparam int SPD       = mode_sel_pkg::SPEED_W;
  localparam int TERM_N    = mode_sel_pkg::TERM_N;
  localparam int FUNC_W    = mode_sel_pkg::FUNC_W;

  typedef struct packed {
    mode_sel_pkg::op_mode_t          mode;
    logic [2:0]                      select;
    logic                            hold_valid;
    logic                            hold_fwd;
    logic                            hold_rev;
    logic [SPD-1:0]                  hold_speed;
    logic                            panel_fwd;
    logic                            panel_rev;
    logic                            stop_latch;
    logic [mode_sel_pkg::KEY_N-1:0]  key_prev;
    logic                            run_fwd;
    logic                            run_rev;
    logic [SPD-1:0]                  speed;
    logic                            out_stop;
    logic                            ilk;
    logic                            wr_ack;
    logic                            wr_nak;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [mode_sel_pkg::SYNC_W-1:0] pins_sync;

  pin_sync u_sync (
    .clk        (clk),
    .arst_n     (arst_n),
    .pins_async ({term_pins, panel_ext_key, panel_mode_key,
                  panel_stop_key, panel_rev_key, panel_fwd_key,
                  preset_speed_input, inching_speed_input,
                  current_input_select, reverse_start_input,
                  forward_start_input}),
    .pins_sync  (pins_sync)
  );

  function automatic logic select_legal(input logic [2:0] v);
    return (v != 3'h5);
  endfunction

  function automatic mode_sel_pkg::op_mode_t power_on_mode(
      input logic [2:0] v);
    unique case (v)
      mode_sel_pkg::SEL_PU_FIXED: return mode_sel_pkg::MODE_PU;
      mode_sel_pkg::SEL_COMB_1,
      mode_sel_pkg::SEL_COMB_2:   return mode_sel_pkg::MODE_COMB;
      default:                    return mode_sel_pkg::MODE_EXT;
    endcase
  endfunction

  // Returns {assigned, level} for terminals carrying one function code
  function automatic logic [1:0] term_match(
      input logic [TERM_N*FUNC_W-1:0] codes,
      input logic [TERM_N-1:0]        pins,
      input logic [FUNC_W-1:0]        code);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < TERM_N; i++) begin
      if (codes[i*FUNC_W +: FUNC_W] == code) begin
        r[1] = 1'b1;
        r[0] = r[0] | pins[i];
      end
    end
    return r;
  endfunction

  // Terminal 2/4, preset and inching speed priority
  function automatic logic [SPD-1:0] ext_speed(
      input logic inch, input logic pre, input logic cur,
      input logic [SPD-1:0] s_inch, input logic [SPD-1:0] s_pre,
      input logic [SPD-1:0] s_t4, input logic [SPD-1:0] s_t2);
    if (inch) begin
      return s_inch;
    end else if (pre) begin
      return s_pre;
    end else if (cur) begin
      return s_t4;
    end
    return s_t2;
  endfunction

  logic [TERM_N-1:0]              term_s;
  logic [mode_sel_pkg::KEY_N-1:0] keys_now;
  logic [mode_sel_pkg::KEY_N-1:0] press;
  logic [1:0]                     m_ilk;
  logic [1:0]                     m_stop;
  logic                           ilk_on;
  logic                           stopped;
  logic                           want_pu;
  logic                           want_ext;
  logic                           want_net;
  logic                           may_switch;
  logic                           wr_ok;
  logic                           cmd_fwd;
  logic                           cmd_rev;
  logic [SPD-1:0]                 cmd_speed;
  logic [SPD-1:0]                 spd_ext;
  mode_sel_pkg::op_mode_t         target;

  always_comb begin
    s_next        = s_reg;
    s_next.wr_ack = 1'b0;
    s_next.wr_nak = 1'b0;
    term_s   = pins_sync[mode_sel_pkg::PIN_TERM0 +: TERM_N];
    keys_now = pins_sync[mode_sel_pkg::KEY_FWD +: mode_sel_pkg::KEY_N];
    press    = keys_now & ~s_reg.key_prev;
    s_next.key_prev = keys_now;
    stopped  = !motor_running;

    // RQ17 interlock terminal binding
    m_ilk  = term_match(input_function_codes, term_s,
                        mode_sel_pkg::FUNC_INTERLOCK);
    m_stop = term_match(input_function_codes, term_s,
                        mode_sel_pkg::FUNC_OUTPUT_STOP);
    // RQ18 output-stop stands in for interlock
    if (m_ilk[1]) begin
      ilk_on = m_ilk[0];
    end else if (m_stop[1]) begin
      ilk_on = m_stop[0];
    end else begin
      // Unassigned interlock must not lock the drive out
      ilk_on = 1'b1;
    end
    s_next.ilk = ilk_on;

    spd_ext = ext_speed(pins_sync[mode_sel_pkg::PIN_INCHING],
                        pins_sync[mode_sel_pkg::PIN_PRESET],
                        pins_sync[mode_sel_pkg::PIN_CUR_SEL],
                        inching_speed, preset_speed,
                        terminal_4_speed, terminal_2_speed);

    // RQ3 panel key request
    want_pu  = press[mode_sel_pkg::KEY_PU - mode_sel_pkg::KEY_FWD];
    // RQ12 panel external key
    want_ext = press[mode_sel_pkg::KEY_EXT - mode_sel_pkg::KEY_FWD];
    // RQ14 link command back to external
    want_ext = want_ext | net_to_ext_cmd;
    want_net = net_to_net_cmd;

    if (want_ext) begin
      target = mode_sel_pkg::MODE_EXT;
    end else if (want_net) begin
      target = mode_sel_pkg::MODE_NET;
    end else begin
      target = mode_sel_pkg::MODE_PU;
    end

    may_switch = 1'b0;
    unique case (s_reg.select)
      mode_sel_pkg::SEL_EXT_PU: may_switch = stopped;
      // RQ2 external fixed, network only
      mode_sel_pkg::SEL_EXT_FIXED:
        may_switch = stopped && (target != mode_sel_pkg::MODE_PU);
      // RQ10 switchover while running
      mode_sel_pkg::SEL_SWITCHOVER: may_switch = 1'b1;
      // RQ19 interlock on permits switching
      mode_sel_pkg::SEL_INTERLOCK: may_switch = stopped && ilk_on;
      // RQ6 RQ7 RQ9 fixed modes refuse
      default: may_switch = 1'b0;
    endcase

    if ((want_pu || want_ext || want_net) && may_switch
        && target != s_reg.mode) begin
      // RQ11 RQ13 RQ15 keep direction and speed
      if (target != mode_sel_pkg::MODE_EXT && motor_running) begin
        s_next.hold_valid = 1'b1;
        s_next.hold_fwd   = s_reg.run_fwd;
        s_next.hold_rev   = s_reg.run_rev;
        s_next.hold_speed = s_reg.speed;
        s_next.panel_fwd  = s_reg.run_fwd;
        s_next.panel_rev  = s_reg.run_rev;
      end else begin
        // RQ12 external pins take over
        s_next.hold_valid = 1'b0;
      end
      s_next.mode = target;
    end

    // New source command retires the retained values
    if ((s_reg.mode == mode_sel_pkg::MODE_PU && panel_speed_set) ||
        (s_reg.mode == mode_sel_pkg::MODE_NET && net_cmd_valid)) begin
      s_next.hold_valid = 1'b0;
    end

    // Panel run keys latch direction
    if (s_reg.mode == mode_sel_pkg::MODE_PU ||
        (s_reg.mode == mode_sel_pkg::MODE_COMB &&
         s_reg.select == mode_sel_pkg::SEL_COMB_2)) begin
      if (press[0]) begin
        s_next.panel_fwd  = 1'b1;
        s_next.panel_rev  = 1'b0;
        s_next.stop_latch = 1'b0;
      end else if (press[1]) begin
        s_next.panel_fwd  = 1'b0;
        s_next.panel_rev  = 1'b1;
        s_next.stop_latch = 1'b0;
      end
    end

    cmd_fwd   = 1'b0;
    cmd_rev   = 1'b0;
    cmd_speed = spd_ext;
    unique case (s_reg.mode)
      // RQ4 external sources
      mode_sel_pkg::MODE_EXT: begin
        cmd_fwd   = pins_sync[mode_sel_pkg::PIN_FWD];
        cmd_rev   = pins_sync[mode_sel_pkg::PIN_REV];
        cmd_speed = spd_ext;
      end
      mode_sel_pkg::MODE_PU: begin
        cmd_fwd   = s_reg.panel_fwd;
        cmd_rev   = s_reg.panel_rev;
        cmd_speed = s_reg.hold_valid ? s_reg.hold_speed : panel_speed;
      end
      mode_sel_pkg::MODE_NET: begin
        cmd_fwd   = s_reg.hold_valid ? s_reg.hold_fwd : net_fwd;
        cmd_rev   = s_reg.hold_valid ? s_reg.hold_rev : net_rev;
        cmd_speed = s_reg.hold_valid ? s_reg.hold_speed : net_speed;
      end
      mode_sel_pkg::MODE_COMB: begin
        if (s_reg.select == mode_sel_pkg::SEL_COMB_1) begin
          // RQ7 RQ8 panel speed, preset and terminal 4 override
          cmd_fwd = pins_sync[mode_sel_pkg::PIN_FWD];
          cmd_rev = pins_sync[mode_sel_pkg::PIN_REV];
          if (pins_sync[mode_sel_pkg::PIN_PRESET]) begin
            cmd_speed = preset_speed;
          end else if (pins_sync[mode_sel_pkg::PIN_CUR_SEL]) begin
            cmd_speed = terminal_4_speed;
          end else begin
            cmd_speed = panel_speed;
          end
        end else begin
          // RQ9 external speed, panel start
          cmd_fwd   = s_reg.panel_fwd;
          cmd_rev   = s_reg.panel_rev;
          cmd_speed = spd_ext;
        end
      end
    endcase

    // RQ21 stop key in every mode
    if (press[2] && (stop_key_select ||
                     s_reg.mode == mode_sel_pkg::MODE_PU)) begin
      s_next.stop_latch = 1'b1;
      s_next.panel_fwd  = 1'b0;
      s_next.panel_rev  = 1'b0;
    end else if (!cmd_fwd && !cmd_rev) begin
      // Released start lets the stop latch go
      s_next.stop_latch = 1'b0;
    end

    // RQ19 output stop in external mode under interlock
    s_next.out_stop =
      (s_reg.select == mode_sel_pkg::SEL_INTERLOCK && ilk_on &&
       s_reg.mode == mode_sel_pkg::MODE_EXT) ||
      (m_stop[0] && !(s_reg.select == mode_sel_pkg::SEL_INTERLOCK &&
                      !m_ilk[1]));
    s_next.run_fwd = cmd_fwd && !cmd_rev && !s_reg.stop_latch;
    s_next.run_rev = cmd_rev && !cmd_fwd && !s_reg.stop_latch;
    s_next.speed   = cmd_speed;

    wr_ok = 1'b0;
    if (wr_req) begin
      if (wr_is_mode_select) begin
        // RQ22 RQ23 legal values, only when stopped
        wr_ok = stopped && select_legal(wr_mode_value) &&
                !write_protect_select;
      end else if (s_reg.select == mode_sel_pkg::SEL_INTERLOCK) begin
        // RQ20 interlock off blocks writes
        wr_ok = s_reg.ilk && !write_protect_select;
      end else begin
        // RQ5 external mode write refusal
        wr_ok = !write_protect_select &&
                (s_reg.mode != mode_sel_pkg::MODE_EXT || wr_ext_writable);
      end
      s_next.wr_ack = wr_ok;
      s_next.wr_nak = !wr_ok;
    end
    if (wr_req && wr_is_mode_select && wr_ok) begin
      s_next.select     = wr_mode_value;
      s_next.mode       = power_on_mode(wr_mode_value);
      s_next.hold_valid = 1'b0;
      s_next.panel_fwd  = 1'b0;
      s_next.panel_rev  = 1'b0;
    end

    // RQ16 forced external mode
    if (s_next.select == mode_sel_pkg::SEL_INTERLOCK && !ilk_on) begin
      s_next.mode       = mode_sel_pkg::MODE_EXT;
      s_next.hold_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg        <= '0;
      // RQ1 external mode after power-on
      s_reg.mode   <= mode_sel_pkg::MODE_EXT;
      s_reg.select <= mode_sel_pkg::SEL_RESET;
      s_reg.ilk    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wr_ack                = s_reg.wr_ack;
  assign wr_nak                = s_reg.wr_nak;
  assign operation_mode_select = s_reg.select;
  assign op_mode               = s_reg.mode;
  assign run_forward           = s_reg.run_fwd && !s_reg.out_stop;
  assign run_reverse           = s_reg.run_rev && !s_reg.out_stop;
  assign speed_cmd             = s_reg.speed;
  assign output_stop           = s_reg.out_stop;
  assign interlock_active      = s_reg.ilk;

endmodule

// >>> net_master_model.sv
// Purpose: Network master issuing link mode-change pulses.
// Assumes: Bench asks through net_req, one cycle per request.
// Notes:   Speed word churns; no run command is ever issued.
`timescale 1ns/1ps
module net_master_model (
  input  wire logic        clk,
  input  wire logic [1:0]  net_req,
  output logic             net_to_net_cmd,
  output logic             net_to_ext_cmd,
  output logic             net_cmd_valid,
  output logic             net_fwd,
  output logic             net_rev,
  output logic [15:0]      net_speed
);
  initial net_speed = 16'h5a5a;
  assign net_cmd_valid = 1'b0;
  assign net_fwd = 1'b0;
  assign net_rev = 1'b0;
  always @(posedge clk) begin
    net_to_net_cmd <= net_req[0];
    net_to_ext_cmd <= net_req[1];
    // Never valid, so stale words must not be taken
    net_speed <= net_speed + 16'h1;
  end
endmodule

// >>> op_mode_selector_props.sv
// Purpose: Port-level checks of the operation mode selector.
// Assumes: Write answers come one cycle after the request.
// Notes:   Attached by bind below.
`timescale 1ns/1ps
module op_mode_selector_props (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        wr_req,
  input wire logic        wr_is_mode_select,
  input wire logic [2:0]  wr_mode_value,
  input wire logic        motor_running,
  input wire logic        write_protect_select,
  input wire logic        wr_ack,
  input wire logic        wr_nak,
  input wire logic [2:0]  operation_mode_select,
  input wire logic [3:0]  op_mode,
  input wire logic        run_forward,
  input wire logic        run_reverse,
  input wire logic        output_stop,
  input wire logic        interlock_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  write_answer_a: assert property (wr_req |=> wr_ack != wr_nak)
    else $error("write not answered once");
  no_spurious_a: assert property ((wr_ack || wr_nak) |-> $past(wr_req))
    else $error("answer without request");
  running_nak_a: assert property (wr_req && wr_is_mode_select
    && motor_running |=> wr_nak) else $error("select written while running");
  bad_value_a: assert property (wr_req && wr_is_mode_select
    && wr_mode_value == 3'h5 |=> wr_nak && $stable(operation_mode_select))
    else $error("unsupported select taken");
  protect_nak_a: assert property (wr_req && write_protect_select
    |=> wr_nak) else $error("protected write taken");
  lock_nak_a: assert property (wr_req && !wr_is_mode_select
    && operation_mode_select == 3'h7 && !interlock_active |=> wr_nak)
    else $error("write taken with interlock off");
  panel_fixed_a: assert property (operation_mode_select == 3'h1
    |-> op_mode == 4'h2) else $error("setting 1 not panel");
  comb_fixed_a: assert property (operation_mode_select
    inside {3'h3, 3'h4} |-> op_mode == 4'h8)
    else $error("combined mode left");
  ext_fixed_a: assert property (operation_mode_select == 3'h2
    |-> op_mode != 4'h2) else $error("setting 2 in panel mode");
  lock_force_a: assert property (operation_mode_select == 3'h7
    && !interlock_active |-> ##[0:2] op_mode == 4'h1)
    else $error("interlock off not forcing external");
  stop_gate_a: assert property ($stable(op_mode)
    && $stable(operation_mode_select) && operation_mode_select == 3'h7
    && op_mode == 4'h1 && interlock_active |-> output_stop)
    else $error("no output stop under interlock");
endmodule
bind op_mode_selector op_mode_selector_props u_op_mode_selector_props (.*);

// >>> op_mode_selector_bench.sv
// Purpose: Self-checking bench of the operation mode selector.
// Assumes: Pin effects settle within four clocks.
// Notes:   Select writes run from a row table, then hand tests.
`timescale 1ns/1ps
module op_mode_selector_bench;
  logic clk, arst_n, forward_start_input, reverse_start_input;
  logic current_input_select, inching_speed_input, preset_speed_input;
  logic panel_fwd_key, panel_rev_key, panel_stop_key, panel_mode_key;
  logic panel_ext_key, panel_speed_set, net_fwd, net_rev, net_cmd_valid;
  logic net_to_ext_cmd, net_to_net_cmd, motor_running, stop_key_select;
  logic write_protect_select, wr_req, wr_is_mode_select, wr_ext_writable;
  logic wr_ack, wr_nak, run_forward, run_reverse, output_stop;
  logic interlock_active;
  logic [4:0]  term_pins;
  logic [39:0] input_function_codes;
  logic [15:0] terminal_2_speed, terminal_4_speed, preset_speed;
  logic [15:0] inching_speed, panel_speed, net_speed, speed_cmd;
  logic [2:0]  wr_mode_value, operation_mode_select, sel_exp;
  logic [3:0]  op_mode;
  logic [1:0]  net_req;
  logic [15:0] spd_exp [4];
  int          n_fail, n_compared;
  typedef struct packed {logic [2:0] v; logic nak; logic [3:0] m;} row_t;
  row_t rows [8] = '{'{3'h1, 1'b0, 4'h2}, '{3'h3, 1'b0, 4'h8},
    '{3'h4, 1'b0, 4'h8}, '{3'h5, 1'b1, 4'h8}, '{3'h2, 1'b0, 4'h1},
    '{3'h6, 1'b0, 4'h1}, '{3'h7, 1'b0, 4'h1}, '{3'h0, 1'b0, 4'h1}};

  op_mode_selector u_op_mode_selector (.*);
  net_master_model u_net_master_model (.*);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(logic [15:0] g, logic [15:0] e, string s);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, s);
    end
  endtask
  task automatic wr(logic m, logic [2:0] v);
    @(posedge clk);
    wr_req <= 1'b1;
    wr_is_mode_select <= m;
    wr_mode_value <= v;
    @(posedge clk);
    wr_req <= 1'b0;
    #1;
  endtask
  task automatic wt;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(25 * 3000);
    n_fail++;
    summarize;
  end

  initial begin
    {arst_n, forward_start_input, reverse_start_input, current_input_select,
     inching_speed_input, preset_speed_input, panel_fwd_key, panel_rev_key,
     panel_stop_key, panel_mode_key, panel_ext_key, panel_speed_set,
     motor_running, write_protect_select, wr_req, wr_is_mode_select,
     wr_ext_writable} = '0;
    {term_pins, input_function_codes, wr_mode_value, net_req} = '0;
    stop_key_select = 1'b1;
    {terminal_2_speed, terminal_4_speed} = {16'h1234, 16'h4444};
    {preset_speed, inching_speed, panel_speed} = {16'h7777, 16'h0101, 16'h0a0a};
    spd_exp = '{16'h0101, 16'h7777, 16'h4444, 16'h1234};
    n_fail = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk(op_mode, 4'h1, "reset mode");
    chk(operation_mode_select, 3'h0, "reset select");
    sel_exp = 3'h0;
    foreach (rows[i]) begin
      wr(1'b1, rows[i].v);
      chk(wr_nak, rows[i].nak, "select answer");
      sel_exp = rows[i].nak ? sel_exp : rows[i].v;
      chk(operation_mode_select, sel_exp, "select value");
      chk(op_mode, rows[i].m, "row mode");
    end
    $display("select table done");
    wr(1'b0, 3'h0);
    chk(wr_nak, 1'b1, "ext write refused");
    wr_ext_writable <= 1'b1;
    wr(1'b0, 3'h0);
    chk(wr_ack, 1'b1, "designated write");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {inching_speed_input, preset_speed_input, current_input_select}
        <= 3'b100 >> i;
      wt;
      chk(speed_cmd, spd_exp[i], "ext speed source");
    end
    forward_start_input <= 1'b1;
    wt;
    chk(run_forward, 1'b1, "ext start");
    panel_stop_key <= 1'b1;
    wt;
    chk(run_forward, 1'b0, "stop key");
    {panel_stop_key, forward_start_input} <= 2'b00;
    panel_mode_key <= 1'b1;
    wt;
    chk(op_mode, 4'h2, "to panel");
    {panel_mode_key, panel_ext_key} <= 2'b01;
    wt;
    chk(op_mode, 4'h1, "to external");
    panel_ext_key <= 1'b0;
    wr(1'b1, 3'h2);
    panel_mode_key <= 1'b1;
    wt;
    chk(op_mode, 4'h1, "fixed external");
    panel_mode_key <= 1'b0;
    wr(1'b1, 3'h3);
    {reverse_start_input, current_input_select} <= 2'b11;
    wt;
    chk(run_reverse, 1'b1, "comb start");
    chk(speed_cmd, 16'h4444, "comb terminal 4");
    current_input_select <= 1'b0;
    wt;
    chk(speed_cmd, 16'h0a0a, "comb panel");
    reverse_start_input <= 1'b0;
    $display("external tests done");
    wr(1'b1, 3'h6);
    {forward_start_input, motor_running} <= 2'b11;
    wt;
    wr(1'b1, 3'h0);
    chk(wr_nak, 1'b1, "write while running");
    net_req <= 2'h1;
    @(posedge clk) net_req <= 2'h0;
    terminal_2_speed <= 16'h2222;
    wt;
    chk(op_mode, 4'h4, "to network running");
    chk(speed_cmd, 16'h1234, "speed kept");
    chk(run_forward, 1'b1, "direction kept");
    net_req <= 2'h2;
    @(posedge clk) net_req <= 2'h0;
    wt;
    chk(op_mode, 4'h1, "network to ext");
    chk(speed_cmd, 16'h2222, "ext speed back");
    {forward_start_input, motor_running} <= 2'b00;
    wt;
    $display("switchover done");
    wr(1'b1, 3'h4);
    panel_fwd_key <= 1'b1;
    wt;
    chk(run_forward, 1'b1, "panel start");
    chk(speed_cmd, 16'h2222, "external speed");
    {panel_fwd_key, panel_stop_key} <= 2'b01;
    wt;
    panel_stop_key <= 1'b0;
    input_function_codes <= 40'h0c;
    wr(1'b1, 3'h7);
    wt;
    chk(interlock_active, 1'b0, "interlock bound");
    chk(op_mode, 4'h1, "forced external");
    wr(1'b0, 3'h0);
    chk(wr_nak, 1'b1, "locked write");
    wr(1'b1, 3'h7);
    chk(wr_ack, 1'b1, "select write");
    term_pins <= 5'h01;
    wt;
    chk(output_stop, 1'b1, "ext output stop");
    panel_mode_key <= 1'b1;
    wt;
    chk(op_mode, 4'h2, "switch allowed");
    {panel_mode_key, term_pins} <= 6'h00;
    wt;
    chk(op_mode, 4'h1, "forced from panel");
    input_function_codes <= 40'h1800;
    term_pins <= 5'h01;
    wt;
    chk(interlock_active, 1'b0, "stop pin as lock");
    write_protect_select <= 1'b1;
    wr(1'b1, 3'h7);
    chk(wr_nak, 1'b1, "protected");
    $display("interlock done");
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(operation_mode_select, 3'h0, "reset again");
    chk(op_mode, 4'h1, "reset ext");
    arst_n <= 1'b1;
    wt;
    chk(speed_cmd, 16'h2222, "ext after reset");
    $display("reset done");
    summarize;
  end
endmodule
